// File: dpob_bank.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dpob_bank
  import dpob_pkg::*;
#(
  parameter logic [31:0] UNIT_TYPE_VAL = 32'h00010002,   // arbitrary neutral value
  parameter logic [39:0] MODEL_NAME    = 40'h4D4F44454C, // arbitrary neutral value
  parameter logic [7:0]  HW_VERSION    = 8'h11,          // arbitrary neutral value
  parameter logic [15:0] SW_VERSION    = 16'h2222,       // arbitrary neutral value
  parameter bit          CLOSED_LOOP   = 1'b0,           // closed-loop drive variant
  parameter int          MS_CYCLES     = CYC_PER_MS      // clock cycles per millisecond
)(
  input  wire logic        CLK,          // system clock
  input  wire logic        RST_N,        // synchronous reset, active low
  input  wire logic        CE,           // clock enable, freezes state when low unless RST_N is low
  input  wire logic        WR,           // object write strobe
  input  wire logic        RD,           // object read strobe
  input  wire logic [15:0] INDEX,        // object index
  input  wire logic [7:0]  SUBINDEX,     // object sub-index
  input  wire logic [31:0] WDATA,        // write value
  output logic      [31:0] RDATA,        // read value, low bits of strings
  output logic             ACK,          // access accepted pulse
  output logic             ERR,          // access rejected pulse
  input  wire logic [15:0] ENC_RES,      // encoder resolution object value
  input  wire logic        MOTION,       // motor running
  input  wire logic        ALARM,        // drive alarm
  input  wire logic        BRAKE,        // holding brake release request
  input  wire logic        IN_POS,       // in-position
  input  wire logic [5:0]  DIN,          // raw digital inputs, input one is bit 0
  output logic [1:0]       DOUT,         // digital outputs, first is bit 0
  output logic [5:0]       DIN_STATE,    // polarity-corrected inputs
  output logic [15:0]      PEAK_CUR,     // peak run current, mA
  output logic [15:0]      PULSES_REV,   // effective pulses per revolution
  output logic [15:0]      CUR_CMD,      // winding current command, mA
  output logic             STANDBY,      // standby active
  output logic [5:0][3:0]  IN_FUNC,      // input function selects
  output logic             SAVE_REQ,     // save parameters pulse
  output logic             RESTORE_REQ   // factory restore pending at next power-up
);

  ////////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    logic [31:0]     rdata;    // read answer
    logic            ack;      // accepted
    logic            err;      // rejected
    logic [15:0]     peak;     // peak current
    logic [15:0]     ppr;      // pulses per revolution setting
    logic [15:0]     idle;     // idle delay ms
    logic [15:0]     pct;      // standby percent
    logic [1:0][3:0] ofunc;    // output functions
    logic [1:0]      opol;     // output polarity
    logic [5:0][3:0] ifunc;    // input functions
    logic [5:0]      ipol;     // input polarity
    logic [1:0]      dout;     // output pins
    logic [5:0]      din;      // corrected inputs
    logic [15:0]     eff_ppr;  // effective pulses per rev
    logic [15:0]     cur;      // current command
    logic            save;     // save pulse
    logic            restore;  // restore flag
    dpob_mode_t      mode;     // idle state
    logic            stby;     // standby flag, registered copy of the standby state
    logic [15:0]     ms_cnt;   // elapsed idle ms
    logic [31:0]     cyc_cnt;  // cycles in current ms
  } dpob_state_t;

  dpob_state_t st_r;   // registered state
  dpob_state_t st_nxt; // next state

  logic        w_ok;   // write value in range
  logic [15:0] wv;     // low half of write value
  logic [31:0] prod;   // peak times percent
  logic [1:0]  fsrc;   // function-driven output level

  assign wv = WDATA[15:0];

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_nxt        = st_r;
    st_nxt.ack    = 1'b0;
    st_nxt.err    = 1'b0;
    st_nxt.save   = 1'b0;
    w_ok          = 1'b0;
    fsrc          = 2'b00;
    prod          = 32'h00000000;
    // writes with range check
    if (WR) begin
      case (INDEX)
        IDX_SAVE:       w_ok = (SUBINDEX == SUB_ONE) && (WDATA == CMD_VALUE);
        IDX_RESTORE:    w_ok = (SUBINDEX == SUB_ONE) && (WDATA == CMD_VALUE);
        IDX_PEAK_CUR:   w_ok = (WDATA[31:16] == 16'h0000) && (wv >= PEAK_MIN) && (wv <= PEAK_MAX);
        IDX_PULSES_REV: w_ok = (WDATA[31:16] == 16'h0000) && (wv >= PPR_MIN);
        IDX_IDLE_DELAY: w_ok = (WDATA[31:16] == 16'h0000) && (wv >= IDLE_MIN);
        IDX_STBY_PCT:   w_ok = (WDATA[31:16] == 16'h0000) && (wv <= PCT_MAX);
        IDX_OUT_FUNC:   w_ok = (SUBINDEX >= 8'h01) && (SUBINDEX <= 8'h02) && (WDATA <= 32'(OFUNC_MAX));
        IDX_OUT_POL:    w_ok = (WDATA <= 32'(OPOL_MAX));
        IDX_IN_FUNC:    w_ok = (SUBINDEX >= 8'h01) && (SUBINDEX <= 8'h06) && (WDATA <= 32'(IFUNC_MAX));
        IDX_IN_POL:     w_ok = (WDATA <= 32'(IPOL_MAX));
        default:        w_ok = 1'b0; // read-only or unknown objects
      endcase
      st_nxt.ack = w_ok;
      st_nxt.err = !w_ok;
      if (w_ok) begin
        case (INDEX)
          IDX_SAVE:       st_nxt.save = 1'b1;
          IDX_RESTORE:    st_nxt.restore = 1'b1;
          IDX_PEAK_CUR:   st_nxt.peak = wv;
          IDX_PULSES_REV: st_nxt.ppr  = wv;
          IDX_IDLE_DELAY: st_nxt.idle = wv;
          IDX_STBY_PCT:   st_nxt.pct  = wv;
          IDX_OUT_FUNC:   st_nxt.ofunc[SUBINDEX[0] ? 0 : 1] = wv[3:0];
          IDX_OUT_POL:    st_nxt.opol = wv[1:0];
          IDX_IN_FUNC:    st_nxt.ifunc[3'(SUBINDEX[2:0] - 3'h1)] = wv[3:0];
          IDX_IN_POL:     st_nxt.ipol = wv[5:0];
          default:        st_nxt.ack = 1'b0;
        endcase
      end
    end else if (RD) begin
      // reads of every object except IDX_ENC_RES, which is rejected like an unknown index
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = 32'h00000000;
      case (INDEX)
        IDX_UNIT_TYPE:  st_nxt.rdata = UNIT_TYPE_VAL;
        IDX_MODEL_NAME: st_nxt.rdata = MODEL_NAME[31:0];
        IDX_HW_VERSION: st_nxt.rdata = {24'h000000, HW_VERSION};
        IDX_SW_VERSION: st_nxt.rdata = {16'h0000, SW_VERSION};
        IDX_SAVE,
        IDX_RESTORE:    st_nxt.rdata = (SUBINDEX == SUB_COUNT) ? {24'h000000, SUB_MAX} : 32'h00000000;
        IDX_PEAK_CUR:   st_nxt.rdata = {16'h0000, st_r.peak};
        IDX_PULSES_REV: st_nxt.rdata = {16'h0000, st_r.ppr};
        IDX_IDLE_DELAY: st_nxt.rdata = {16'h0000, st_r.idle};
        IDX_STBY_PCT:   st_nxt.rdata = {16'h0000, st_r.pct};
        IDX_OUT_FUNC:   st_nxt.rdata = {28'h0000000, st_r.ofunc[SUBINDEX[0] ? 0 : 1]};
        IDX_OUT_POL:    st_nxt.rdata = {30'h0, st_r.opol};
        IDX_IN_FUNC:    st_nxt.rdata = {28'h0000000, st_r.ifunc[3'(SUBINDEX[2:0] - 3'h1)]};
        IDX_IN_POL:     st_nxt.rdata = {26'h0000000, st_r.ipol};
        IDX_DIG_INPUTS: st_nxt.rdata = {26'h0000000, st_r.din};
        default: begin
          st_nxt.ack = 1'b0;
          st_nxt.err = 1'b1;
        end
      endcase
    end
    // input polarity: normally closed inputs are inverted
    st_nxt.din = DIN ~^ st_r.ipol;
    // output drive from function select
    for (int i = 0; i < 2; i++) begin
      case (st_r.ofunc[i][1:0])
        OF_CUSTOM: fsrc[i] = st_r.opol[i];
        OF_ALARM:  fsrc[i] = ALARM ~^ st_r.opol[i];
        OF_BRAKE:  fsrc[i] = BRAKE ~^ st_r.opol[i];
        OF_INPOS:  fsrc[i] = IN_POS ~^ st_r.opol[i];
        default:   fsrc[i] = 1'b0;
      endcase
    end
    st_nxt.dout = fsrc;
    // effective resolution
    st_nxt.eff_ppr = CLOSED_LOOP ? ENC_RES : st_r.ppr;
    // idle timing and standby
    case (st_r.mode)
      DPOB_RUN: begin
        if (!MOTION) begin
          st_nxt.mode    = DPOB_WAIT;
          st_nxt.ms_cnt  = 16'h0000;
          st_nxt.cyc_cnt = 32'h00000000;
        end
      end
      DPOB_WAIT: begin
        if (MOTION) begin
          st_nxt.mode = DPOB_RUN;
        end else if (st_r.cyc_cnt == 32'(MS_CYCLES - 1)) begin
          st_nxt.cyc_cnt = 32'h00000000;
          st_nxt.ms_cnt  = 16'(st_r.ms_cnt + 16'h0001);
          if (16'(st_r.ms_cnt + 16'h0001) >= st_r.idle) begin
            st_nxt.mode = DPOB_STBY;
          end
        end else begin
          st_nxt.cyc_cnt = 32'(st_r.cyc_cnt + 32'h00000001);
        end
      end
      DPOB_STBY: begin
        if (MOTION) begin
          st_nxt.mode = DPOB_RUN;
        end
      end
      default: st_nxt.mode = DPOB_RUN;
    endcase
    prod = 32'(st_r.peak) * 32'(st_r.pct);
    st_nxt.cur = (st_nxt.mode == DPOB_STBY) ? 16'(prod / 32'(PCT_MAX)) : st_r.peak;
    // standby output kept in its own flip-flop so the pin is not a state decode
    st_nxt.stby = (st_nxt.mode == DPOB_STBY);
    if (!RST_N) begin
      st_nxt.rdata   = 32'h00000000;
      st_nxt.ack     = 1'b0;
      st_nxt.err     = 1'b0;
      st_nxt.peak    = PEAK_DEF;
      st_nxt.ppr     = PPR_DEF;
      st_nxt.idle    = IDLE_DEF;
      st_nxt.pct     = PCT_DEF;
      st_nxt.ofunc   = {OFUNC_DEF1, OFUNC_DEF0};
      st_nxt.opol    = OPOL_DEF[1:0];
      st_nxt.ifunc   = IFUNC_DEFS;
      st_nxt.ipol    = IPOL_DEF[5:0];
      st_nxt.dout    = 2'b00;
      st_nxt.din     = 6'h00;
      st_nxt.eff_ppr = PPR_DEF;
      st_nxt.cur     = PEAK_DEF;
      st_nxt.save    = 1'b0;
      st_nxt.restore = 1'b0;
      st_nxt.mode    = DPOB_RUN;
      st_nxt.stby    = 1'b0;
      st_nxt.ms_cnt  = 16'h0000;
      st_nxt.cyc_cnt = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK) begin
    if (CE || !RST_N) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state record
  assign RDATA       = st_r.rdata;
  assign ACK         = st_r.ack;
  assign ERR         = st_r.err;
  assign DOUT        = st_r.dout;
  assign DIN_STATE   = st_r.din;
  assign PEAK_CUR    = st_r.peak;
  assign PULSES_REV  = st_r.eff_ppr;
  assign CUR_CMD     = st_r.cur;
  assign STANDBY     = st_r.stby;
  assign IN_FUNC     = st_r.ifunc;
  assign SAVE_REQ    = st_r.save;
  assign RESTORE_REQ = st_r.restore;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_bad_peak;
    WR && CE && (INDEX == IDX_PEAK_CUR) && (WDATA > 32'(PEAK_MAX));
  endsequence

  AST_PEAK_REJECT: assert property (@(posedge CLK) disable iff (!RST_N)
    s_bad_peak |=> ERR && $stable(PEAK_CUR)) else $error("out of range peak accepted");
  AST_SAVE_PULSE: assert property (@(posedge CLK) disable iff (!RST_N)
    (WR && CE && INDEX == IDX_SAVE && SUBINDEX == SUB_ONE && WDATA == CMD_VALUE) |=> SAVE_REQ)
    else $error("save not pulsed");
  AST_RESTORE_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    RESTORE_REQ |=> RESTORE_REQ) else $error("restore flag dropped");
  AST_UNIT_TYPE: assert property (@(posedge CLK) disable iff (!RST_N)
    (RD && !WR && CE && INDEX == IDX_UNIT_TYPE) |=> RDATA == UNIT_TYPE_VAL) else $error("unit type wrong");
  AST_RO_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
    (WR && CE && INDEX == IDX_SW_VERSION) |=> ERR && !ACK) else $error("version object writable");
  AST_CUSTOM_OUT: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && st_r.ofunc[0] == 4'(OF_CUSTOM) && $stable(st_r.opol)) |=> DOUT[0] == $past(st_r.opol[0]))
    else $error("custom output not following polarity");
  AST_STBY_CUR: assert property (@(posedge CLK) disable iff (!RST_N)
    (STANDBY && $stable(STANDBY)) |-> CUR_CMD <= PEAK_CUR) else $error("standby current above peak");
  AST_MOTION_WAKE: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && MOTION) |=> !STANDBY) else $error("standby kept during motion");
  AST_PPR_SRC: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !CLOSED_LOOP) |=> PULSES_REV == $past(st_r.ppr)) else $error("resolution source wrong");

endmodule

// File: dpob_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// fieldbus master model: one object access per call, strobe held one cycle
module dpob_master
  import dpob_pkg::*;
(
  input  wire logic        CLK,      // system clock
  output logic             WR,       // write strobe
  output logic             RD,       // read strobe
  output logic [15:0]      INDEX,    // object index
  output logic [7:0]       SUBINDEX, // object sub-index
  output logic [31:0]      WDATA,    // write value
  output logic             MOTION,   // motor running, from the master's motion commands
  input  wire logic [31:0] RDATA,    // read value
  input  wire logic        ACK,      // access accepted
  input  wire logic        ERR       // access rejected
);
  // idle bus at time zero
  initial begin
    WR = 1'b0;
    RD = 1'b0;
    INDEX = 16'h0000;
    SUBINDEX = 8'h00;
    WDATA = 32'h00000000;
    MOTION = 1'b0;
  end
  // strobe for one cycle, then take the answer in the following cycle
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                      output logic [31:0] rd, output logic ack, output logic err);
    @(posedge CLK);
    WR <= w;
    RD <= !w;
    INDEX <= idx;
    SUBINDEX <= sub;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b0;
    INDEX <= ~idx;       // released qualifiers do not keep the old value
    SUBINDEX <= ~sub;
    WDATA <= ~d;
    #1;
    rd = RDATA;
    ack = ACK;
    err = ERR;
  endtask
  // start or stop the motor
  task automatic run(input logic v);
    @(posedge CLK);
    MOTION <= v;
  endtask
  // stop the motor, then issue a save or restore command
  task automatic store(input logic [15:0] idx, output logic ack);
    logic [31:0] rd;
    logic        err;
    run(1'b0);
    xfer(1'b1, idx, SUB_ONE, CMD_VALUE, rd, ack, err);
  endtask
endmodule

// File: dpob_pkg.sv
package dpob_pkg;
  // object dictionary indices
  localparam logic [15:0] IDX_UNIT_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_MODEL_NAME  = 16'h1001;
  localparam logic [15:0] IDX_HW_VERSION  = 16'h1009;
  localparam logic [15:0] IDX_SW_VERSION  = 16'h100A;
  localparam logic [15:0] IDX_SAVE        = 16'h1010;
  localparam logic [15:0] IDX_RESTORE     = 16'h1011;
  localparam logic [15:0] IDX_PEAK_CUR    = 16'h2000;
  localparam logic [15:0] IDX_PULSES_REV  = 16'h2001;
  localparam logic [15:0] IDX_IDLE_DELAY  = 16'h2002;
  localparam logic [15:0] IDX_STBY_PCT    = 16'h2003;
  localparam logic [15:0] IDX_OUT_FUNC    = 16'h2005;
  localparam logic [15:0] IDX_OUT_POL     = 16'h2006;
  localparam logic [15:0] IDX_IN_FUNC     = 16'h2007;
  localparam logic [15:0] IDX_IN_POL      = 16'h2008;
  localparam logic [15:0] IDX_ENC_RES     = 16'h2020;
  localparam logic [15:0] IDX_DIG_INPUTS  = 16'h60FD;
  // sub-indices
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_ONE         = 8'h01;
  localparam logic [7:0]  SUB_MAX         = 8'h01;
  localparam logic [31:0] CMD_VALUE       = 32'h00000001;
  // unit type field layout: profile in 15:0, type info in 31:16
  localparam int          UT_PROFILE_LSB  = 0;
  localparam int          UT_INFO_LSB     = 16;
  // ranges and defaults
  localparam logic [15:0] PEAK_MIN        = 16'h0064;
  localparam logic [15:0] PEAK_MAX        = 16'h1770;
  localparam logic [15:0] PEAK_DEF        = 16'h0BB8;
  localparam logic [15:0] PPR_MIN         = 16'h00C8;
  localparam logic [15:0] PPR_DEF         = 16'h2710;
  localparam logic [15:0] IDLE_MIN        = 16'h00C8;
  localparam logic [15:0] IDLE_DEF        = 16'h01F4;
  localparam logic [15:0] PCT_MAX         = 16'h0064;
  localparam logic [15:0] PCT_DEF         = 16'h0032;
  localparam logic [15:0] OFUNC_MAX       = 16'h0003;
  localparam logic [15:0] IFUNC_MAX       = 16'h0008;
  localparam logic [15:0] OPOL_MAX        = 16'h0003;
  localparam logic [15:0] OPOL_DEF        = 16'h0003;
  localparam logic [15:0] IPOL_MAX        = 16'h003F;
  localparam logic [15:0] IPOL_DEF        = 16'h003F;
  // output function codes
  localparam logic [1:0]  OF_CUSTOM       = 2'h0;
  localparam logic [1:0]  OF_ALARM        = 2'h1;
  localparam logic [1:0]  OF_BRAKE        = 2'h2;
  localparam logic [1:0]  OF_INPOS        = 2'h3;
  localparam logic [3:0]  OFUNC_DEF0      = 4'h1;
  localparam logic [3:0]  OFUNC_DEF1      = 4'h2;
  localparam logic [23:0] IFUNC_DEFS      = 24'h632100;  // 4 bits per input, input one lowest
  // timing: one millisecond at 50 MHz
  localparam int          CLK_HZ          = 50000000;
  localparam int          MS_PER_S        = 1000;
  localparam int          CYC_PER_MS      = CLK_HZ / MS_PER_S;
  // idle state machine
  typedef enum logic [1:0] {DPOB_RUN, DPOB_WAIT, DPOB_STBY} dpob_mode_t;
endpackage

// File: drive_parameter_object_bank_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the parameter object bank
module drive_parameter_object_bank_bench;
  import dpob_pkg::*;
  logic            clk, rst_n, wr, rd, ack, err, motion, alarm, brake, in_pos; // bus and io
  logic            standby, save_req, restore_req, a, e, ce;                   // status and enable
  logic [15:0]     enc_res;                                                    // encoder resolution
  logic [15:0]     index, peak_cur, pulses_rev, cur_cmd;                       // settings
  logic [7:0]      subindex;                                                   // sub-index
  logic [31:0]     wdata, rdata, r;                                            // data
  logic [5:0]      din, din_state;                                             // inputs
  logic [1:0]      dout;                                                       // outputs
  logic [5:0][3:0] in_func;                                                    // input selects
  int              error_cnt = 0, cmp_count = 0, cyc = 0, n;                   // counters
////////////////////////////////////////////////////////////////////////////////
  // design with a short millisecond; identity values are arbitrary
  dpob_bank #(.UNIT_TYPE_VAL(32'h00030005), .MODEL_NAME(40'h4142434445),
    .SW_VERSION(16'h6B7C), .MS_CYCLES(5)) dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .WR(wr), .RD(rd), .INDEX(index), .SUBINDEX(subindex),
    .WDATA(wdata), .RDATA(rdata), .ACK(ack), .ERR(err), .ENC_RES(enc_res), .MOTION(motion),
    .ALARM(alarm), .BRAKE(brake), .IN_POS(in_pos), .DIN(din), .DOUT(dout), .DIN_STATE(din_state),
    .PEAK_CUR(peak_cur), .PULSES_REV(pulses_rev), .CUR_CMD(cur_cmd), .STANDBY(standby),
    .IN_FUNC(in_func), .SAVE_REQ(save_req), .RESTORE_REQ(restore_req));
  // master on the object bus
  dpob_master m (.CLK(clk), .WR(wr), .RD(rd), .INDEX(index), .SUBINDEX(subindex), .WDATA(wdata),
    .MOTION(motion), .RDATA(rdata), .ACK(ack), .ERR(err));
////////////////////////////////////////////////////////////////////////////////
  // clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait edges, then settle
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // read an object and compare
  task automatic rdc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    m.xfer(1'b0, idx, sub, 32'h00000000, r, a, e);
    chk(32'(a), 32'h00000001);
    chk(r, exp);
  endtask
  // write an object, expecting acceptance or refusal
  task automatic wrc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v, input logic bad);
    m.xfer(1'b1, idx, sub, v, r, a, e);
    chk(32'(e), 32'(bad));
    chk(32'(a), 32'(!bad));
  endtask
////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    enc_res = 16'h04D2;
    alarm = 1'b0;
    brake = 1'b0;
    in_pos = 1'b0;
    din = 6'h2D;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(0);
    chk(32'(peak_cur), 32'(PEAK_DEF));
    chk(32'(pulses_rev), 32'(PPR_DEF));
    chk(32'(in_func), 32'(IFUNC_DEFS));
    m.run(1'b1);
    // reset values of the settings
    rdc(IDX_PEAK_CUR, SUB_COUNT, 32'(PEAK_DEF));
    rdc(IDX_PULSES_REV, SUB_COUNT, 32'(PPR_DEF));
    rdc(IDX_IDLE_DELAY, SUB_COUNT, 32'(IDLE_DEF));
    rdc(IDX_STBY_PCT, SUB_COUNT, 32'(PCT_DEF));
    rdc(IDX_OUT_FUNC, 8'h01, 32'h00000001);
    rdc(IDX_OUT_FUNC, 8'h02, 32'h00000002);
    rdc(IDX_OUT_POL, SUB_COUNT, 32'h00000003);
    rdc(IDX_IN_POL, SUB_COUNT, 32'h0000003F);
    for (n = 1; n <= 6; n++) begin
      rdc(IDX_IN_FUNC, 8'(n), 32'(IFUNC_DEFS[4*n-4 +: 4]));
    end
    // read-only identity objects, writes refused
    rdc(IDX_UNIT_TYPE, SUB_COUNT, 32'h00030005);
    rdc(IDX_MODEL_NAME, SUB_COUNT, 32'h42434445);
    rdc(IDX_HW_VERSION, SUB_COUNT, 32'h00000011);
    rdc(IDX_SW_VERSION, SUB_COUNT, 32'h00006B7C);
    wrc(IDX_SW_VERSION, SUB_COUNT, 32'h00000001, 1'b1);
    wrc(IDX_UNIT_TYPE, SUB_COUNT, 32'h00000001, 1'b1);
    wrc(16'h3000, SUB_COUNT, 32'h00000001, 1'b1);
    rdc(IDX_SAVE, SUB_COUNT, 32'(SUB_MAX));
    rdc(IDX_RESTORE, SUB_COUNT, 32'(SUB_MAX));
    // range boundaries; refused writes keep the value
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h00001771, 1'b1);
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h00000063, 1'b1);
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h00001770, 1'b0);
    rdc(IDX_PEAK_CUR, SUB_COUNT, 32'h00001770);
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h00000064, 1'b0);
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h00010064, 1'b1);
    rdc(IDX_PEAK_CUR, SUB_COUNT, 32'h00000064);
    wrc(IDX_PULSES_REV, SUB_COUNT, 32'h000000C7, 1'b1);
    wrc(IDX_PULSES_REV, SUB_COUNT, 32'h0000FFFF, 1'b0);
    tick(1);
    chk(32'(pulses_rev), 32'h0000FFFF);
    // clock enable low freezes the bank: a legal write is not taken
    @(posedge clk);
    ce <= 1'b0;
    m.xfer(1'b1, IDX_PEAK_CUR, SUB_COUNT, 32'h00000BB8, r, a, e);
    chk(32'(a), 32'h00000000);
    @(posedge clk);
    ce <= 1'b1;
    rdc(IDX_PEAK_CUR, SUB_COUNT, 32'h00000064);
    wrc(IDX_IDLE_DELAY, SUB_COUNT, 32'h000000C7, 1'b1);
    wrc(IDX_STBY_PCT, SUB_COUNT, 32'h00000065, 1'b1);
    wrc(IDX_STBY_PCT, SUB_COUNT, 32'h00000000, 1'b0);
    wrc(IDX_OUT_FUNC, 8'h01, 32'h00000004, 1'b1);
    wrc(IDX_OUT_POL, SUB_COUNT, 32'h00000004, 1'b1);
    wrc(IDX_IN_POL, SUB_COUNT, 32'h00000040, 1'b1);
    wrc(IDX_IN_FUNC, 8'h06, 32'h00000009, 1'b1);
    wrc(IDX_IN_FUNC, 8'h06, 32'h00000008, 1'b0);
    tick(1);
    chk(32'(in_func[5]), 32'h00000008);
    // save pulse and sticky restore
    m.store(IDX_SAVE, a);
    chk(32'(save_req), 32'h00000001);
    chk(32'(restore_req), 32'h00000000);
    tick(1);
    chk(32'(save_req), 32'h00000000);
    m.store(IDX_RESTORE, a);
    tick(3);
    chk(32'(restore_req), 32'h00000001);
    // custom outputs follow the polarity bits
    wrc(IDX_OUT_FUNC, 8'h01, 32'(OF_CUSTOM), 1'b0);
    wrc(IDX_OUT_FUNC, 8'h02, 32'(OF_CUSTOM), 1'b0);
    wrc(IDX_OUT_POL, SUB_COUNT, 32'h00000001, 1'b0);
    tick(2);
    chk(32'(dout), 32'h00000001);
    wrc(IDX_OUT_POL, SUB_COUNT, 32'h00000002, 1'b0);
    tick(2);
    chk(32'(dout), 32'h00000002);
    // alarm on one, brake on two, with mixed polarity
    wrc(IDX_OUT_FUNC, 8'h01, 32'(OF_ALARM), 1'b0);
    wrc(IDX_OUT_FUNC, 8'h02, 32'(OF_BRAKE), 1'b0);
    @(posedge clk);
    alarm <= 1'b1;
    brake <= 1'b1;
    tick(2);
    chk(32'(dout), 32'h00000002);
    @(posedge clk);
    alarm <= 1'b0;
    brake <= 1'b0;
    tick(2);
    chk(32'(dout), 32'h00000001);
    wrc(IDX_OUT_FUNC, 8'h01, 32'(OF_INPOS), 1'b0);
    wrc(IDX_OUT_POL, SUB_COUNT, 32'h00000003, 1'b0);
    @(posedge clk);
    in_pos <= 1'b1;
    tick(2);
    chk(32'(dout), 32'h00000001);
    // inputs with polarity applied
    chk(32'(din_state), 32'h0000002D);
    rdc(IDX_DIG_INPUTS, SUB_COUNT, 32'h0000002D);
    wrc(IDX_IN_POL, SUB_COUNT, 32'h00000015, 1'b0);
    tick(2);
    chk(32'(din_state), 32'h00000007);
    rdc(IDX_DIG_INPUTS, SUB_COUNT, 32'h00000007);
    // idle delay, standby current and wake-up
    wrc(IDX_PEAK_CUR, SUB_COUNT, 32'h000003E8, 1'b0);
    wrc(IDX_STBY_PCT, SUB_COUNT, 32'h00000014, 1'b0);
    wrc(IDX_IDLE_DELAY, SUB_COUNT, 32'h000000C8, 1'b0);
    m.run(1'b1);
    tick(3);
    chk(32'(cur_cmd), 32'h000003E8);
    m.run(1'b0);
    n = 0;
    while (standby !== 1'b1 && n < 1100) begin
      tick(1);
      n++;
    end
    chk(32'(n >= 995 && n <= 1005), 32'h00000001);
    chk(32'(cur_cmd), 32'h000000C8);
    m.run(1'b1);
    tick(1);
    chk(32'(standby), 32'h00000000);
    tick(1);
    chk(32'(cur_cmd), 32'h000003E8);
    wrap_up();
  end
endmodule
